// ---- verilog/rxsw_pkg.sv ----
// Package with the constants and carriers of the receive status writeback.
package rxsw_pkg;
  // Status word field positions.
  localparam int OWN_BIT   = 31;
  localparam int DONE_BIT  = 30;
  localparam int CNT_HI    = 29;
  localparam int CNT_LO    = 16;
  localparam int ERR_BIT   = 15;
  localparam int RSV_BIT   = 14;
  localparam int TYPE_HI   = 13;
  localparam int TYPE_LO   = 12;
  localparam int SHORT_BIT = 11;
  localparam int FIRST_BIT = 9;
  localparam int LAST_BIT  = 8;
  localparam int OVER_BIT  = 7;
  localparam int LATE_BIT  = 6;
  localparam int CRC_BIT   = 1;
  localparam int CNT_W     = CNT_HI - CNT_LO + 1;
  // Frame length limits in bytes.
  localparam logic [CNT_W-1:0] MIN_FRAME = 14'h0040;
  localparam logic [CNT_W-1:0] MAX_FRAME = 14'h0800;
  // Packet type codes.
  localparam logic [1:0] TYPE_NORMAL = 2'h0;
  localparam logic [1:0] TYPE_RSVD   = 2'h3;
  // Register byte offsets.
  localparam logic [3:0] REG_CFG  = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h8;
  localparam logic [3:0] REG_CNT  = 4'hC;
  // Network configuration word: loopback mode field.
  localparam int LB_HI = 11;
  localparam int LB_LO = 10;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // Interrupt status bits.
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_ERR   = 1;
  localparam int IRQ_OWNER = 2;
  localparam int IRQ_W     = 3;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

  // One descriptor event from the data mover.
  typedef struct packed {
    logic [31:0]      addr;
    logic             owner;
    logic             last;
    logic [CNT_W-1:0] len;
    logic             crc_err;
    logic             phy_err;
    logic             late_col;
  } rxsw_evt_s;

  // One status word write to host memory.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } rxsw_wr_s;
endpackage : rxsw_pkg

// ---- verilog/rxsw_top.sv ----
// Receive descriptor status writeback engine with a Wishbone slave.
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module rxsw_top (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Descriptor events
  input  wire logic             evt_valid_i,
  input  rxsw_pkg::rxsw_evt_s   evt_i,
  output logic                  evt_ready_o,
  // Status word writes
  output logic                  wr_valid_o,
  output rxsw_pkg::rxsw_wr_s    wr_o,
  input  wire logic             wr_ready_i,
  // Interrupt
  output logic                  irq_o
);
  import rxsw_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WR_SEG, ST_WR_LAST, ST_WR_FIRST}
    rxsw_state_e;

  rxsw_state_e            state_q;
  logic                   in_frame_q;
  logic [31:0]            first_addr_q;
  rxsw_evt_s              frame_q;
  logic [1:0]             type_q;
  logic [31:0]            cfg_q;
  logic [IRQ_W-1:0]       stat_q;
  logic [IRQ_W-1:0]       mask_q;
  logic [31:0]            cnt_q;
  logic                   take;
  logic                   wr_done;
  logic                   bus_req;
  logic [IRQ_W-1:0]       ev;
  logic [1:0]             lb_w;

  assign take    = evt_valid_i && evt_ready_o;
  assign wr_done = wr_valid_o && wr_ready_i;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign lb_w    = wb_dat_i[LB_HI:LB_LO];

  // Builds a status word; frame fields appear only when full is set.
  function automatic logic [31:0] mk_word(input rxsw_evt_s e,
                                          input logic [1:0] ty,
                                          input logic first,
                                          input logic last,
                                          input logic full);
    logic [31:0] w;
    logic        over;
    logic        short;
    logic        crc;
    w     = 32'h0000_0000;
    over  = e.len > MAX_FRAME;
    short = e.len < MIN_FRAME;
    crc   = e.crc_err || e.phy_err;
    w[FIRST_BIT] = first;
    w[LAST_BIT]  = last;
    if (full)
    begin
      w[DONE_BIT] = 1'b1;
      w[CNT_HI:CNT_LO] = e.len;
      w[ERR_BIT] = crc || e.late_col || over || short;
      w[TYPE_HI:TYPE_LO] = ty;
      w[SHORT_BIT] = short;
      w[OVER_BIT] = over;
      w[LATE_BIT] = e.late_col;
      w[CRC_BIT] = crc;
    end
    w[RSV_BIT] = 1'b0;
    w[OWN_BIT] = 1'b0;
    return w;
  endfunction : mk_word

  // Descriptor sequencing and status writes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q      <= ST_IDLE;
      in_frame_q   <= 1'b0;
      first_addr_q <= 32'h0000_0000;
      frame_q      <= '0;
      type_q       <= TYPE_NORMAL;
      wr_valid_o   <= 1'b0;
      wr_o         <= '0;
      evt_ready_o  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          evt_ready_o <= 1'b1;
          if (take && evt_i.owner)
          begin
            evt_ready_o <= 1'b0;
            wr_valid_o  <= 1'b1;
            wr_o.addr   <= evt_i.addr;
            if (!in_frame_q)
              first_addr_q <= evt_i.addr;
            if (!evt_i.last)
            begin
              // release a middle or first buffer at once
              wr_o.data  <= mk_word(evt_i, TYPE_NORMAL, !in_frame_q,
                                    1'b0, 1'b0);
              in_frame_q <= 1'b1;
              state_q    <= ST_WR_SEG;
            end
            else
            begin
              // last event means all data is in host memory
              frame_q   <= evt_i;
              type_q    <= cfg_q[LB_HI:LB_LO];
              wr_o.data <= mk_word(evt_i, cfg_q[LB_HI:LB_LO],
                                   !in_frame_q, 1'b1, 1'b1);
              state_q   <= ST_WR_LAST;
            end
          end
        end
        ST_WR_SEG:
        begin
          if (wr_done)
          begin
            wr_valid_o  <= 1'b0;
            evt_ready_o <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
        ST_WR_LAST:
        begin
          if (wr_done)
          begin
            in_frame_q <= 1'b0;
            // revisit the first descriptor of a split frame
            if (in_frame_q)
            begin
              wr_o.addr <= first_addr_q;
              wr_o.data <= mk_word(frame_q, type_q, 1'b1, 1'b0, 1'b1);
              state_q   <= ST_WR_FIRST;
            end
            else
            begin
              wr_valid_o  <= 1'b0;
              evt_ready_o <= 1'b1;
              state_q     <= ST_IDLE;
            end
          end
        end
        ST_WR_FIRST:
        begin
          if (wr_done)
          begin
            wr_valid_o  <= 1'b0;
            evt_ready_o <= 1'b1;
            state_q     <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Interrupt events: frame finished, frame with error, refused descriptor.
  always_comb
  begin
    ev            = '0;
    ev[IRQ_DONE]  = wr_done && ((state_q == ST_WR_LAST && !in_frame_q) ||
                                state_q == ST_WR_FIRST);
    ev[IRQ_ERR]   = ev[IRQ_DONE] && wr_o.data[ERR_BIT];
    ev[IRQ_OWNER] = take && !evt_i.owner;
  end

  // Wishbone slave: one wait state, ack for a single cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      cfg_q    <= CFG_RESET;
      mask_q   <= MASK_RESET;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          REG_CFG:  wb_dat_o <= cfg_q;
          REG_STAT: wb_dat_o <= {{(32-IRQ_W){1'b0}}, stat_q};
          REG_MASK: wb_dat_o <= {{(32-IRQ_W){1'b0}}, mask_q};
          REG_CNT:  wb_dat_o <= cnt_q;
          default:  wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (bus_req && wb_we_i && wb_adr_i == REG_CFG && wb_sel_i[1])
      begin
        // the reserved type code is never stored
        cfg_q[LB_HI:LB_LO] <= (lb_w == TYPE_RSVD) ? TYPE_NORMAL : lb_w;
      end
      if (bus_req && wb_we_i && wb_adr_i == REG_MASK && wb_sel_i[0])
        mask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Sticky status: a new event wins over the clearing read.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stat_q <= '0;
    else if (bus_req && !wb_we_i && wb_adr_i == REG_STAT)
      stat_q <= ev;
    else
      stat_q <= stat_q | ev;
  end

  // Completed frame counter and interrupt line.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 32'h0000_0000;
      irq_o <= 1'b0;
    end
    else
    begin
      if (ev[IRQ_DONE])
        cnt_q <= cnt_q + 32'h0000_0001;
      irq_o <= |((stat_q | ev) & mask_q);
    end
  end

  // Checks on the words written and the write sequence.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  owner_cleared_a: assert property (
    wr_valid_o |-> !wr_o.data[OWN_BIT])
    else $error("Descriptor written back still owned by hardware.");
  refused_desc_a: assert property (
    take && !evt_i.owner |=> !wr_valid_o && state_q == ST_IDLE)
    else $error("Descriptor not owned by hardware was used.");
  done_at_ends_a: assert property (
    wr_valid_o && wr_o.data[DONE_BIT] |->
      wr_o.data[FIRST_BIT] || wr_o.data[LAST_BIT])
    else $error("Frame status written into a middle descriptor.");
  err_summary_a: assert property (
    wr_valid_o |-> wr_o.data[ERR_BIT] == (wr_o.data[CRC_BIT] ||
      wr_o.data[LATE_BIT] || wr_o.data[OVER_BIT] || wr_o.data[SHORT_BIT]))
    else $error("Error summary disagrees with error flags.");
  type_legal_a: assert property (
    wr_valid_o |-> wr_o.data[TYPE_HI:TYPE_LO] != TYPE_RSVD)
    else $error("Reserved packet type written.");
  rsv_zero_a: assert property (
    wr_valid_o |-> !wr_o.data[RSV_BIT])
    else $error("Reserved status bit written as one.");
  short_flag_a: assert property (
    wr_valid_o && wr_o.data[DONE_BIT] |->
      wr_o.data[SHORT_BIT] == (wr_o.data[CNT_HI:CNT_LO] < MIN_FRAME))
    else $error("Short frame flag wrong for byte count.");
  over_flag_a: assert property (
    wr_valid_o && wr_o.data[DONE_BIT] |->
      wr_o.data[OVER_BIT] == (wr_o.data[CNT_HI:CNT_LO] > MAX_FRAME))
    else $error("Oversize flag wrong for byte count.");
  last_status_a: assert property (
    take && evt_i.owner && evt_i.last |=> wr_valid_o &&
      wr_o.data[CNT_HI:CNT_LO] == $past(evt_i.len) &&
      wr_o.data[CRC_BIT] == $past(evt_i.crc_err || evt_i.phy_err) &&
      wr_o.data[LATE_BIT] == $past(evt_i.late_col) &&
      wr_o.data[TYPE_HI:TYPE_LO] == $past(cfg_q[LB_HI:LB_LO]))
    else $error("Last descriptor status does not match the frame.");
  first_revisit_a: assert property (
    state_q == ST_WR_LAST && wr_done && in_frame_q |=>
      wr_valid_o && wr_o.addr == first_addr_q && wr_o.data[DONE_BIT] &&
      wr_o.data[FIRST_BIT] && !wr_o.data[LAST_BIT])
    else $error("First descriptor not updated after the last one.");
  seg_release_a: assert property (
    take && evt_i.owner && !evt_i.last |=> wr_valid_o &&
      !wr_o.data[LAST_BIT] && !wr_o.data[DONE_BIT] &&
      wr_o.addr == $past(evt_i.addr))
    else $error("Filled buffer not released on its own.");
  write_hold_a: assert property (
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_o))
    else $error("Status write changed before it was taken.");
  seg_no_done_a: assert property (
    wr_valid_o && state_q == ST_WR_SEG |-> !wr_o.data[DONE_BIT])
    else $error("Completion flag set before the frame ended.");
  // One write slot keeps the first address safe until it is revisited.
  single_write_a: assert property (
    wr_valid_o |-> !evt_ready_o)
    else $error("Descriptor accepted while a status write is pending.");
  cfg_type_legal_a: assert property (
    cfg_q[LB_HI:LB_LO] != TYPE_RSVD)
    else $error("Reserved loopback code held in the configuration.");
  // The acknowledge must never stay high two cycles in a row, even while a master holds its request.
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held for more than one cycle.");
  irq_masked_a: assert property (
    mask_q == '0 |=> !irq_o)
    else $error("Interrupt raised with every source masked.");

  single_frame_c: cover property (
    take && evt_i.owner && evt_i.last && !in_frame_q);
  split_frame_c: cover property (state_q == ST_WR_FIRST && wr_done);
  refused_c: cover property (take && !evt_i.owner);
  typed_frame_c: cover property (
    wr_valid_o && wr_o.data[TYPE_HI:TYPE_LO] != TYPE_NORMAL);
  error_frame_c: cover property (ev[IRQ_ERR]);
endmodule : rxsw_top

// ---- verif/rxsw_host_mem.sv ----
// Host memory model that accepts status word writes after a set stall.
`timescale 1ns/1ps
module rxsw_host_mem (
  // Clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  // Status word writes from the engine
  input  wire logic           wr_valid_i,
  input  rxsw_pkg::rxsw_wr_s  wr_i,
  output logic                wr_ready_o,
  // Wait cycles before each accept
  input  wire logic [3:0]     stall_i
);
  import rxsw_pkg::*;

  rxsw_wr_s   log_q [16];
  logic [3:0] n_q;
  logic [3:0] wait_q;

  // software side
  // Memory only records words; the driver reads a descriptor after its
  // owner bit came back clear and judges status only in first or last.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_ready_o <= 1'b0;
      wait_q     <= 4'h0;
      n_q        <= 4'h0;
    end
    else if (wr_valid_i && wr_ready_o)
    begin
      log_q[n_q] <= wr_i;
      n_q        <= n_q + 4'h1;
      wr_ready_o <= 1'b0;
      wait_q     <= 4'h0;
    end
    else if (wr_valid_i && wait_q >= stall_i)
      wr_ready_o <= 1'b1;
    else if (wr_valid_i)
      wait_q <= wait_q + 4'h1;
  end
endmodule : rxsw_host_mem

// ---- verif/rxsw_top_tb_top.sv ----
// Testbench for the receive status writeback engine.
`timescale 1ns/1ps
module rxsw_top_tb_top;
  import rxsw_pkg::*;

  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        wb_cyc_i    = 1'b0;
  logic        wb_stb_i    = 1'b0;
  logic        wb_we_i     = 1'b0;
  logic [3:0]  wb_adr_i    = 4'h0;
  logic [3:0]  wb_sel_i    = 4'hF;
  logic [31:0] wb_dat_i    = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        evt_valid_i = 1'b0;
  rxsw_evt_s   evt_i       = '0;
  logic        evt_ready_o;
  logic        wr_valid_o;
  rxsw_wr_s    wr_o;
  logic        wr_ready_i;
  logic        irq_o;
  logic [3:0]  stall       = 4'h0;
  logic [31:0] rd;
  int          error_cnt   = 0;
  int          check_count = 0;
  int          frames      = 0;

  rxsw_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .evt_valid_i(evt_valid_i), .evt_i(evt_i),
    .evt_ready_o(evt_ready_o), .wr_valid_o(wr_valid_o), .wr_o(wr_o),
    .wr_ready_i(wr_ready_i), .irq_o(irq_o));
  rxsw_host_mem HM (.clk_i(clk_i), .rst_i(rst_i), .wr_valid_i(wr_valid_o),
    .wr_i(wr_o), .wr_ready_o(wr_ready_i), .stall_i(stall));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic results;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask : chk

  // Waits on rising edges until the engine takes events again.
  task automatic await(input string nm);
    int i;
    for (i = 0; i < 40 && evt_ready_o !== 1'b1; i++)
      @(posedge clk_i);
    if (evt_ready_o !== 1'b1)
    begin
      chk(nm, 32'h1, 32'h0);
      results();
    end
  endtask : await

  task automatic wb(input logic we, input logic [3:0] adr, sel,
                    input logic [31:0] dat);
    int   i;
    logic got;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    got = 1'b0;
    for (i = 0; i < 40 && !got; i++)
    begin
      @(posedge clk_i);
      got = (wb_ack_o === 1'b1);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (!got)
    begin
      chk("wb_ack_o", 32'h1, 32'h0);
      results();
    end
    @(posedge clk_i);
  endtask : wb

  // Error bits e are crc, phy and late collision, in that order.
  task automatic send(input logic [31:0] a, input logic own, last,
                      input logic [13:0] len, input logic [2:0] e);
    int   i;
    logic got;
    evt_i       <= '{a, own, last, len, e[2], e[1], e[0]};
    evt_valid_i <= 1'b1;
    got = 1'b0;
    for (i = 0; i < 40 && !got; i++)
    begin
      @(posedge clk_i);
      got = (evt_ready_o === 1'b1);
    end
    evt_valid_i <= 1'b0;
    if (!got)
    begin
      chk("evt_ready_o", 32'h1, 32'h0);
      results();
    end
    @(posedge clk_i);
  endtask : send

  function automatic logic [31:0] stat(input logic [13:0] len,
    input logic [2:0] e, input logic [1:0] ty, input logic f, l);
    logic s;
    logic o;
    logic c;
    s = len < 14'h0040;
    o = len > 14'h0800;
    c = e[2] | e[1];
    return {1'b0, 1'b1, len, c | e[0] | o | s, 1'b0, ty, s, 1'b0, f, l,
            o, e[0], 4'h0, c, 1'b0};
  endfunction : stat

  task automatic one(input logic [31:0] a, input logic [13:0] len,
                     input logic [2:0] e, input logic [1:0] ty);
    logic [3:0] n0;
    n0 = HM.n_q;
    send(a, 1'b1, 1'b1, len, e);
    await("frame end");
    frames++;
    chk("write count", {28'h0, n0 + 4'h1}, {28'h0, HM.n_q});
    chk("write addr", a, HM.log_q[n0].addr);
    chk("status word", stat(len, e, ty, 1'b1, 1'b1),
        HM.log_q[n0].data);
    @(posedge clk_i);
  endtask : one

  task automatic t_status;
    logic [13:0] ln [9] = '{14'h0064, 14'h003F, 14'h0040, 14'h0800,
                            14'h0801, 14'h0064, 14'h0064, 14'h0064, 14'h3FFF};
    logic [2:0]  er [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1,
                            3'h0};
    for (int k = 0; k < 9; k++)
      one(32'h1000 + 32'(k * 16), ln[k], er[k], 2'h0);
  endtask : t_status

  task automatic t_types;
    logic [1:0] ty;
    for (int m = 0; m < 4; m++)
    begin
      ty = (m == 3) ? 2'h0 : 2'(m);
      wb(1'b1, REG_CFG, 4'h2, 32'(m) << 10);
      wb(1'b0, REG_CFG, 4'hF, 32'h0);
      chk("config read", {20'h0, ty, 10'h0}, rd);
      one(32'h2000, 14'h0100, 3'h0, ty);
    end
  endtask : t_types

  task automatic t_split;
    logic [3:0]  n0;
    logic [31:0] ea [4] = '{32'h3000, 32'h3010, 32'h3020, 32'h3000};
    logic [31:0] ed [4];
    ed = '{32'h0000_0200, 32'h0, stat(14'h012C, 3'h1, 2'h0, 1'b0, 1'b1),
           stat(14'h012C, 3'h1, 2'h0, 1'b1, 1'b0)};
    stall <= 4'h3;
    n0 = HM.n_q;
    send(ea[0], 1'b1, 1'b0, 14'h0, 3'h0);
    send(ea[1], 1'b1, 1'b0, 14'h0, 3'h0);
    send(ea[2], 1'b1, 1'b1, 14'h012C, 3'h1);
    await("split end");
    frames++;
    for (int k = 0; k < 4; k++)
    begin
      chk("split addr", ea[k],
          HM.log_q[n0 + 4'(k)].addr);
      chk("split data", ed[k],
          HM.log_q[n0 + 4'(k)].data);
    end
    stall <= 4'h0;
    @(posedge clk_i);
  endtask : t_split

  task automatic t_irq;
    logic [3:0] n0;
    wb(1'b0, REG_STAT, 4'hF, 32'h0);
    chk("status read", 32'h3, rd);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    one(32'h4000, 14'h0080, 3'h0, 2'h0);
    wb(1'b1, REG_MASK, 4'h1, 32'h7);
    repeat (3) @(negedge clk_i);
    chk("irq set", 32'h1, {31'h0, irq_o});
    @(posedge clk_i);
    wb(1'b0, REG_STAT, 4'hF, 32'h0);
    chk("status done", 32'h1, rd);
    repeat (3) @(negedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq_o});
    @(posedge clk_i);
    n0 = HM.n_q;
    send(32'h5000, 1'b0, 1'b1, 14'h0080, 3'h0);
    repeat (4) @(negedge clk_i);
    chk("no write", {28'h0, n0}, {28'h0, HM.n_q});
    chk("irq owner", 32'h1, {31'h0, irq_o});
    @(posedge clk_i);
    wb(1'b0, REG_STAT, 4'hF, 32'h0);
    chk("status owner", 32'h4, rd);
    wb(1'b0, REG_CNT, 4'hF, 32'h0);
    chk("frame count", 32'(frames), rd);
  endtask : t_irq

  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_status();
    t_types();
    t_split();
    t_irq();
    results();
  end
endmodule : rxsw_top_tb_top
